// file: sim/tb_tec8_top.sv
// tb_tec8_top: register-level tests of the timer control block.
// assumes the checker is bound in and the pin model drives the pins.
`timescale 1ns/10ps
module tb_tec8_top;
  import tec8_pkg::*;
  logic clk, rst_n, wr_s, rd_s, p17, p33, l17, l33;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic p17_out, p17_oe_n, p33_out, p33_oe_n, irq0, irq1;
  int err_total = 0;
  int total_checks = 0;
  int gap;
  int irq1_n = 0;
  logic [7:0] seq_d [10] = '{8'h01, 8'h09, 8'h0d, 8'h05, 8'h08, 8'h01,
    8'h41, 8'h43, 8'h45, 8'h31};
  logic [7:0] seq_p [10] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01,
    8'h00, 8'h01, 8'h00, 8'h01};
  tec8_top uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .I_P17_IN(p17),
    .I_P33_IN(p33), .I_P17_LATCH(l17), .I_P33_LATCH(l33), .O_RDATA(rdata),
    .O_P17_OUT(p17_out), .O_P17_OE_N(p17_oe_n), .O_P33_OUT(p33_out),
    .O_P33_OE_N(p33_oe_n), .O_IRQ0(irq0), .O_IRQ1(irq1));
  tec8_pin_model partner (.i_clk(clk), .o_p17(p17), .o_p33(p33),
    .o_latch17(l17), .o_latch33(l33));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // match pulses of channel 1, looked at away from the launching edge
  always @(negedge clk) begin
    if (irq1 === 1'b1) irq1_n++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk(rdata, exp);
  endtask : rd
  // pin is registered twice behind the write, so give it three cycles
  task automatic pin(input logic [7:0] exp);
    repeat (3) @(negedge clk);
    chk({7'h00, p17_out}, exp);
  endtask : pin
  // cycles between two match pulses; a bounded wait so a dead timer fails
  task automatic irq_gap(output int n);
    n = 0;
    while (irq0 !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    @(negedge clk);
    while (irq0 !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
  endtask : irq_gap
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rd(TEC8_ADDR_TMC0, 8'h00);
    rd(TEC8_ADDR_TMC1, 8'h00);
    rd(TEC8_ADDR_P1DIR, 8'hff);
    rd(TEC8_ADDR_P3DIR, 8'hff);
    chk({7'h00, p17_oe_n}, 8'h01);
    chk({7'h00, p33_oe_n}, 8'h01);
    $display("test reset done");
    wr(TEC8_ADDR_P1DIR, 8'h7f);
    rd(TEC8_ADDR_P1DIR, 8'h7f);
    chk({7'h00, p17_oe_n}, 8'h00);
    foreach (seq_d[i]) begin
      wr(TEC8_ADDR_TMC0, seq_d[i]);
      pin(seq_p[i]);
      rd(TEC8_ADDR_TMC0, seq_d[i] & TEC8_TMC_STORE_MASK);
    end
    $display("test output control done");
    wr(TEC8_ADDR_CMP0, 8'h03);
    wr(TEC8_ADDR_CSEL0, {5'h00, TEC8_CS_DIV1});
    wr(TEC8_ADDR_TMC0, 8'h03);
    wr(TEC8_ADDR_TMC0, 8'h83);
    irq_gap(gap);
    chk(8'(gap + 1), 8'h04);
    wr(TEC8_ADDR_TMC0, 8'h03);
    rd(TEC8_ADDR_CNT0, 8'h00);
    $display("test interval done");
    for (int e = 0; e < 2; e++) begin
      wr(TEC8_ADDR_CSEL1, 8'(e));
      wr(TEC8_ADDR_CMP1, 8'h02);
      wr(TEC8_ADDR_TMC1, 8'h80);
      partner.pulse(5);
      repeat (2) @(negedge clk);
      rd(TEC8_ADDR_CNT1, 8'h02);
      wr(TEC8_ADDR_TMC1, 8'h00);
      rd(TEC8_ADDR_CNT1, 8'h00);
    end
    chk(8'(irq1_n), 8'h02);
    wr(TEC8_ADDR_TMC1, 8'h09);
    repeat (3) @(negedge clk);
    chk({7'h00, p33_out}, 8'h01);
    $display("test event count done");
    end_of_test();
  end
endmodule : tb_tec8_top

// file: sim/tec8_assertions.sv
// tec8_assertions: port-level checks on the timer control block.
// assumes the bench never reads a mode register right after writing it.
`timescale 1ns/10ps
module tec8_assertions
  import tec8_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_P17_LATCH,
  input wire logic [7:0] O_RDATA,
  input wire logic O_P17_OUT,
  input wire logic O_P33_OE_N,
  input wire logic O_IRQ0
);
  logic [7:0] tmc0_q;
  logic [2:0] since0_q;
  logic wr0;
  assign wr0 = I_WR && I_ADDR == TEC8_ADDR_TMC0;
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the stored mode bits; settle count saturates so pin checks
  // only fire once the registered path has caught up
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tmc0_q <= TEC8_TMC_RST;
      since0_q <= 3'h0;
    end else begin
      if (wr0) tmc0_q <= I_WDATA & TEC8_TMC_STORE_MASK;
      since0_q <= wr0 ? 3'h0 : (since0_q == 3'h4 ? 3'h4 : since0_q + 3'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  a_tmc_zero_bits: assert property ($past(I_RD) &&
    ($past(I_ADDR) == TEC8_ADDR_TMC0 || $past(I_ADDR) == TEC8_ADDR_TMC1)
    |-> O_RDATA[5:2] == 4'h0) else $error("mode strobe bits read nonzero");
  a_tmc_readback: assert property ($past(I_RD) && !$past(I_WR, 2) &&
    $past(I_ADDR) == TEC8_ADDR_TMC0 |-> O_RDATA == $past(tmc0_q))
    else $error("mode register readback wrong");
  a_dir_high_bits: assert property ($past(I_RD) &&
    $past(I_ADDR) == TEC8_ADDR_P3DIR |-> O_RDATA[7:4] == 4'hf)
    else $error("port3 direction upper bits not one");
  a_dir_to_oe: assert property (I_WR && I_ADDR == TEC8_ADDR_P3DIR
    |-> ##2 O_P33_OE_N == $past(I_WDATA[3], 2))
    else $error("pin enable does not follow direction bit");
  a_ff_strobe: assert property (wr0 && I_WDATA[7:6] == 2'b00 &&
    I_WDATA[0] && ^I_WDATA[3:2] && !I_P17_LATCH
    |-> ##4 O_P17_OUT == $past(I_WDATA[3], 4)) else $error("strobe lost");
  a_oe_off_low: assert property (since0_q == 3'h4 && !tmc0_q[0] &&
    !I_P17_LATCH && !$past(I_P17_LATCH) |-> !O_P17_OUT)
    else $error("pin high with output disabled");
  a_pwm_stop_level: assert property (since0_q == 3'h4 &&
    tmc0_q[7:6] == 2'b01 && tmc0_q[0] && !I_P17_LATCH &&
    !$past(I_P17_LATCH) |-> O_P17_OUT == tmc0_q[1])
    else $error("stopped pwm output not inactive");
  a_stop_no_irq: assert property (since0_q == 3'h4 &&
    !tmc0_q[7] |-> !O_IRQ0) else $error("match pulse while stopped");
endmodule : tec8_assertions
bind tec8_top tec8_assertions chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .I_P17_LATCH(I_P17_LATCH), .O_RDATA(O_RDATA), .O_P17_OUT(O_P17_OUT),
  .O_P33_OE_N(O_P33_OE_N), .O_IRQ0(O_IRQ0));

// file: sim/tec8_pin_model.sv
// tec8_pin_model: the board side of the two shared pins.
// assumes the bench calls pulse() from its main sequence only.
`timescale 1ns/10ps
module tec8_pin_model (
  input wire logic i_clk,
  output logic o_p17,
  output logic o_p33,
  output logic o_latch17,
  output logic o_latch33
);
  // latches cleared so the timer output is seen alone on the pin
  initial begin
    o_p17 = 1'b0;
    o_p33 = 1'b0;
    o_latch17 = 1'b0;
    o_latch33 = 1'b0;
  end
  // full pulses on the channel 1 event line, two cycles per level
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(negedge i_clk);
      o_p33 = 1'b1;
      repeat (2) @(negedge i_clk);
      o_p33 = 1'b0;
    end
  endtask : pulse
endmodule : tec8_pin_model

// file: src/tec8_chan.sv
// tec8_chan: one 8-bit counter with compare, output flip-flop and pwm stage.
// assumes the event input is synchronous to the system clock.
`timescale 1ns/10ps
module tec8_chan
  import tec8_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_event,
  tec8_chan_if.chan ch
);

  logic [7:0] cnt_q, cnt_d;
  logic ff_q, ff_d;
  logic pwm_q, pwm_d;
  logic ev_q, ev_d;
  logic irq_q, irq_d;
  logic out_q, out_d;
  logic tick;
  logic run, pwm_mode;

  assign run = ch.tmc[TEC8_BIT_RUN];
  assign pwm_mode = ch.tmc[TEC8_BIT_MODE];

  ////////////////////////////////////////////////////////////////////////////
  // count clock: the selected pin edge (falling or rising) or prescaler tap becomes a one-cycle tick
  always_comb begin
    ev_d = i_event;
    case (ch.csel)
      TEC8_CS_PIN_FALL: tick = ev_q & ~i_event; // RULE20
      TEC8_CS_PIN_RISE: tick = ~ev_q & i_event; // RULE20
      TEC8_CS_DIV1: tick = 1'b1;
      TEC8_CS_DIV2: tick = &ch.prescale[0:0];
      TEC8_CS_DIV4: tick = &ch.prescale[1:0];
      TEC8_CS_DIV64: tick = &ch.prescale[5:0];
      TEC8_CS_DIV256: tick = &ch.prescale[7:0];
      TEC8_CS_DIV4096: tick = &ch.prescale[11:0];
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_d = cnt_q;
    ff_d = ff_q;
    pwm_d = pwm_q;
    irq_d = 1'b0;
    if (!run) begin
      cnt_d = 8'h00; // RULE2 RULE18
      pwm_d = 1'b0; // RULE11
    end else if (tick) begin
      if (!pwm_mode && cnt_q == ch.cmp) begin
        // match: clear, keep counting, one pulse per match
        cnt_d = 8'h00; // RULE15 RULE17
        irq_d = 1'b1; // RULE21
        if (ch.tmc[TEC8_BIT_INV])
          ff_d = ~ff_q; // RULE5
      end else begin
        cnt_d = cnt_q + 8'h01; // RULE19
      end
      if (pwm_mode) begin
        if (cnt_q == 8'hff)
          pwm_d = 1'b1;
        else if (cnt_q == ch.cmp)
          pwm_d = 1'b0;
      end
    end
    // strobes act only in clear-on-match mode, whatever the run bit
    if (!pwm_mode && ch.ff_set)
      ff_d = 1'b1; // RULE4 RULE8
    else if (!pwm_mode && ch.ff_clr)
      ff_d = 1'b0; // RULE4 RULE8
  end

  // pin follows settings at once, running or not
  always_comb begin
    if (!ch.tmc[TEC8_BIT_OE])
      out_d = 1'b0; // RULE6
    else if (pwm_mode)
      out_d = pwm_d ^ ch.tmc[TEC8_BIT_INV]; // RULE5 RULE11 RULE12
    else
      out_d = ff_d; // RULE12
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      ff_q <= 1'b0;
      pwm_q <= 1'b0;
      ev_q <= 1'b0;
      irq_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      pwm_q <= pwm_d;
      ev_q <= ev_d;
      irq_q <= irq_d;
      out_q <= out_d;
    end
  end

  assign ch.count = cnt_q;
  assign ch.pin_out = out_q;
  assign ch.irq = irq_q;

endmodule : tec8_chan

// file: src/tec8_chan_if.sv
// tec8_chan_if: settings and results passed between the top and one channel.
// assumes the top owns all registers and each channel owns counter and pin.
`timescale 1ns/10ps
interface tec8_chan_if;
  logic [7:0] tmc;
  logic [7:0] cmp;
  logic [2:0] csel;
  logic ff_set;
  logic ff_clr;
  logic [12:0] prescale;
  logic [7:0] count;
  logic pin_out;
  logic irq;
  modport top (output tmc, cmp, csel, ff_set, ff_clr, prescale,
               input count, pin_out, irq);
  modport chan (input tmc, cmp, csel, ff_set, ff_clr, prescale,
                output count, pin_out, irq);
endinterface : tec8_chan_if

// file: src/tec8_pkg.sv
// tec8_pkg: register map, field positions, reset values and clock-select codes
// for the 8-bit timer/event counter control block.
// assumes a single system clock; the count clock is derived inside the block.
package tec8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (cpu register port, 16-bit address)
  localparam logic [15:0] TEC8_ADDR_P3DIR = 16'hff23;
  localparam logic [15:0] TEC8_ADDR_TMC1 = 16'hff43;
  localparam logic [15:0] TEC8_ADDR_TMC0 = 16'hff6b;
  localparam logic [15:0] TEC8_ADDR_P1DIR = 16'hff21;
  localparam logic [15:0] TEC8_ADDR_CMP0 = 16'hff66;
  localparam logic [15:0] TEC8_ADDR_CNT0 = 16'hff67;
  localparam logic [15:0] TEC8_ADDR_CSEL0 = 16'hff6a;
  localparam logic [15:0] TEC8_ADDR_CMP1 = 16'hff8a;
  localparam logic [15:0] TEC8_ADDR_CNT1 = 16'hff8b;
  localparam logic [15:0] TEC8_ADDR_CSEL1 = 16'hff8c;

  ////////////////////////////////////////////////////////////////////////////
  // mode control register fields
  localparam int TEC8_BIT_RUN = 7;
  localparam int TEC8_BIT_MODE = 6;
  localparam int TEC8_BIT_SET = 3;
  localparam int TEC8_BIT_CLR = 2;
  localparam int TEC8_BIT_INV = 1;
  localparam int TEC8_BIT_OE = 0;
  // bits 7,6,1,0 are stored; 5,4 fixed zero; 3,2 are strobes
  localparam logic [7:0] TEC8_TMC_STORE_MASK = 8'hc3;
  localparam logic [7:0] TEC8_TMC_RST = 8'h00;
  localparam logic [7:0] TEC8_DIR_RST = 8'hff;
  localparam logic [7:0] TEC8_CMP_RST = 8'h00;
  localparam logic [2:0] TEC8_CSEL_RST = 3'h0;

  // pin assignment inside the port direction registers
  localparam int TEC8_P1_PIN = 7;
  localparam int TEC8_P3_PIN = 3;

  ////////////////////////////////////////////////////////////////////////////
  // count clock selection codes
  localparam logic [2:0] TEC8_CS_PIN_FALL = 3'h0;
  localparam logic [2:0] TEC8_CS_PIN_RISE = 3'h1;
  localparam logic [2:0] TEC8_CS_DIV1 = 3'h2;
  localparam logic [2:0] TEC8_CS_DIV2 = 3'h3;
  localparam logic [2:0] TEC8_CS_DIV4 = 3'h4;
  localparam logic [2:0] TEC8_CS_DIV64 = 3'h5;
  localparam logic [2:0] TEC8_CS_DIV256 = 3'h6;
  localparam logic [2:0] TEC8_CS_DIV4096 = 3'h7;
  localparam int TEC8_PRESCALE_W = 13;

endpackage : tec8_pkg

// file: src/tec8_top.sv
// tec8_top: register port, prescaler and two timer/event counter channels
// with their shared pins (port1 bit7 and port3 bit3).
// assumes a simple synchronous cpu port: one-cycle write strobe, read data
// registered one cycle after the read strobe.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - reset clears mode control register: stopped, output off, match mode
// RULE2 - run bit 0 clears and holds the counter; 1 lets it count
// RULE3 - mode bit 6: 0 clear-and-restart on match, 1 free-running pwm
// RULE4 - bits 3:2 set field: 00 hold, 01 reset, 10 set, 11 prohibited
// RULE5 - bit 1 enables inversion on match, or selects pwm active-low
// RULE6 - output enable 0 forces pin low; 1 passes output flip-flop
// RULE7 - set and reset bits are write-only strobes reading zero
// RULE8 - set and reset strobes ignored in pwm mode
// RULE9 - software writes mode, enable, set/reset, run bits apart, in order
// RULE10 - software stops counting before changing the mode bit
// RULE11 - clearing run bit in pwm mode makes output inactive
// RULE12 - control settings reach the pin at once, running or not
// RULE13 - direction bit 0 output, 1 input; reset sets both to ones
// RULE14 - software clears direction and latch for output; sets direction for input
// RULE15 - on match in clear mode: counter clears, keeps counting, irq raised
// RULE16 - software keeps compare value while running in clear mode
// RULE17 - event mode counts selected pin edges; matches clear and interrupt
// RULE18 - counter also clears when run bit clears, and on reset
// RULE19 - counter increments on rising edge of selected count clock
// RULE20 - select code 000 counts pin falling edges, 001 rising edges
// RULE21 - compare-match irq is a one count-clock pulse per match; here one system clock wide at any clock select
// RULE22 - mode bits 5 and 4 held zero and read zero
module tec8_top
  import tec8_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_P17_IN,
  input wire logic I_P33_IN,
  input wire logic I_P17_LATCH,
  input wire logic I_P33_LATCH,
  output logic [7:0] O_RDATA,
  output logic O_P17_OUT,
  output logic O_P17_OE_N,
  output logic O_P33_OUT,
  output logic O_P33_OE_N,
  output logic O_IRQ0,
  output logic O_IRQ1
);

  tec8_chan_if ch [2] ();

  logic [7:0] tmc_q [2];
  logic [7:0] tmc_d [2];
  logic [7:0] cmp_q [2];
  logic [7:0] cmp_d [2];
  logic [2:0] csel_q [2];
  logic [2:0] csel_d [2];
  logic [1:0] fset_q, fset_d, fclr_q, fclr_d;
  logic [7:0] p1dir_q, p1dir_d, p3dir_q, p3dir_d;
  logic [12:0] pre_q, pre_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] pin_out_q, pin_out_d, oe_n_q, oe_n_d;
  logic [1:0] event_in;
  logic [7:0] cnt_rd [2];
  logic [1:0] irq_w;

  localparam logic [15:0] ADDR_TMC [2] = '{TEC8_ADDR_TMC0, TEC8_ADDR_TMC1};
  localparam logic [15:0] ADDR_CMP [2] = '{TEC8_ADDR_CMP0, TEC8_ADDR_CMP1};
  localparam logic [15:0] ADDR_CSEL [2] = '{TEC8_ADDR_CSEL0, TEC8_ADDR_CSEL1};
  localparam logic [15:0] ADDR_CNT [2] = '{TEC8_ADDR_CNT0, TEC8_ADDR_CNT1};

  assign event_in = {I_P33_IN, I_P17_IN};

  ////////////////////////////////////////////////////////////////////////////
  // per-channel registers and channel instance
  for (genvar g = 0; g < 2; g++) begin : g_ch
    always_comb begin
      tmc_d[g] = tmc_q[g];
      cmp_d[g] = cmp_q[g];
      csel_d[g] = csel_q[g];
      fset_d[g] = 1'b0;
      fclr_d[g] = 1'b0;
      if (I_WR && I_ADDR == ADDR_TMC[g]) begin
        tmc_d[g] = I_WDATA & TEC8_TMC_STORE_MASK; // RULE3 RULE22 RULE7
        // prohibited code 11 is dropped rather than racing set against reset
        fset_d[g] = I_WDATA[TEC8_BIT_SET] & ~I_WDATA[TEC8_BIT_CLR]; // RULE4
        fclr_d[g] = I_WDATA[TEC8_BIT_CLR] & ~I_WDATA[TEC8_BIT_SET]; // RULE4
      end
      if (I_WR && I_ADDR == ADDR_CMP[g])
        cmp_d[g] = I_WDATA;
      if (I_WR && I_ADDR == ADDR_CSEL[g])
        csel_d[g] = I_WDATA[2:0];
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        tmc_q[g] <= TEC8_TMC_RST; // RULE1
        cmp_q[g] <= TEC8_CMP_RST;
        csel_q[g] <= TEC8_CSEL_RST;
        fset_q[g] <= 1'b0;
        fclr_q[g] <= 1'b0;
      end else begin
        tmc_q[g] <= tmc_d[g];
        cmp_q[g] <= cmp_d[g];
        csel_q[g] <= csel_d[g];
        fset_q[g] <= fset_d[g];
        fclr_q[g] <= fclr_d[g];
      end
    end

    assign ch[g].tmc = tmc_q[g];
    assign ch[g].cmp = cmp_q[g];
    assign ch[g].csel = csel_q[g];
    assign ch[g].ff_set = fset_q[g];
    assign ch[g].ff_clr = fclr_q[g];
    assign ch[g].prescale = pre_q;
    assign cnt_rd[g] = ch[g].count;
    assign irq_w[g] = ch[g].irq;

    tec8_chan u_chan (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_event(event_in[g]),
      .ch(ch[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers, prescaler, read mux and pin drive
  always_comb begin
    p1dir_d = p1dir_q;
    p3dir_d = p3dir_q;
    pre_d = pre_q + 13'h0001;
    if (I_WR && I_ADDR == TEC8_ADDR_P1DIR)
      p1dir_d = I_WDATA; // RULE13
    if (I_WR && I_ADDR == TEC8_ADDR_P3DIR)
      p3dir_d = I_WDATA | 8'hf0; // RULE13
    rdata_d = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        TEC8_ADDR_TMC0: rdata_d = tmc_q[0]; // RULE7
        TEC8_ADDR_TMC1: rdata_d = tmc_q[1]; // RULE7
        TEC8_ADDR_CMP0: rdata_d = cmp_q[0];
        TEC8_ADDR_CMP1: rdata_d = cmp_q[1];
        TEC8_ADDR_CSEL0: rdata_d = {5'h00, csel_q[0]};
        TEC8_ADDR_CSEL1: rdata_d = {5'h00, csel_q[1]};
        TEC8_ADDR_CNT0: rdata_d = cnt_rd[0];
        TEC8_ADDR_CNT1: rdata_d = cnt_rd[1];
        TEC8_ADDR_P1DIR: rdata_d = p1dir_q;
        TEC8_ADDR_P3DIR: rdata_d = p3dir_q;
        default: rdata_d = 8'h00;
      endcase
    end
    // pin level is timer output and latch combined; with latch 0 it is pure
    // timer output, which is what software is expected to set up
    pin_out_d[0] = ch[0].pin_out | I_P17_LATCH;
    pin_out_d[1] = ch[1].pin_out | I_P33_LATCH;
    oe_n_d[0] = p1dir_d[TEC8_P1_PIN]; // RULE13
    oe_n_d[1] = p3dir_d[TEC8_P3_PIN]; // RULE13
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      p1dir_q <= TEC8_DIR_RST; // RULE13
      p3dir_q <= TEC8_DIR_RST; // RULE13
      pre_q <= 13'h0000;
      rdata_q <= 8'h00;
      pin_out_q <= 2'h0;
      oe_n_q <= 2'h3;
    end else begin
      p1dir_q <= p1dir_d;
      p3dir_q <= p3dir_d;
      pre_q <= pre_d;
      rdata_q <= rdata_d;
      pin_out_q <= pin_out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_P17_OUT = pin_out_q[0];
  assign O_P33_OUT = pin_out_q[1];
  assign O_P17_OE_N = oe_n_q[0];
  assign O_P33_OE_N = oe_n_q[1];
  assign O_IRQ0 = irq_w[0]; // RULE21
  assign O_IRQ1 = irq_w[1]; // RULE21

endmodule : tec8_top
